// ==== ssr_pkg.sv ====
// package: register map, fields, reset values, timing and types of the soft start sequencer
`default_nettype none
package ssr_pkg;
  // register byte offsets
  localparam logic [4:0] A_CTRL = 5'h00;
  localparam logic [4:0] A_R1   = 5'h04;
  localparam logic [4:0] A_R2   = 5'h08;
  localparam logic [4:0] A_JK   = 5'h0C;
  localparam logic [4:0] A_DEC  = 5'h10;
  localparam logic [4:0] A_DLY  = 5'h14;
  localparam logic [4:0] A_STAT = 5'h18;
  // control fields
  localparam int F_MODE = 0;
  localparam int F_CUST = 3;
  localparam int F_R1CU = 4;
  localparam int F_R2PW = 5;
  localparam int F_KICK = 6;
  localparam int F_DEC  = 7;
  localparam int F_TMEN = 8;
  localparam int F_L60  = 9;
  localparam int F_TSEL = 10;
  localparam int F_RSEL = 12;
  localparam int F_RDEN = 14;
  // ramp, jog/kick, decel and delay fields
  localparam int F_INI = 0;
  localparam int F_LIM = 10;
  localparam int F_TIM = 20;
  localparam int F_JOG = 0;
  localparam int F_KV  = 7;
  localparam int F_KT  = 14;
  localparam int F_DS  = 0;
  localparam int F_DE  = 7;
  localparam int F_DT  = 14;
  localparam int F_TD  = 0;
  localparam int F_RD  = 8;
  localparam int F_SD  = 16;
  // write masks and reset values
  localparam logic [31:0] M_CTRL = 32'h0000_7FFF;
  localparam logic [31:0] M_RAMP = 32'h07FF_FFFF;
  localparam logic [31:0] M_JK   = 32'h003F_FFFF;
  localparam logic [31:0] M_DEC  = 32'h001F_FFFF;
  localparam logic [31:0] M_DLY  = 32'h00FF_FFFF;
  localparam logic [31:0] R_CTRL = 32'h0000_0003;
  localparam logic [31:0] R_R1   = 32'h00A7_D01E;
  localparam logic [31:0] R_R2   = 32'h00A1_4014;
  localparam logic [31:0] R_JK   = 32'h000C_9E14;
  localparam logic [31:0] R_DEC  = 32'h0002_8A3C;
  localparam logic [31:0] R_DLY  = 32'h0002_0505;
  // scales and limits, levels in 0.1 % of full voltage
  localparam logic [9:0]  FULL_V   = 10'h3E8;
  localparam logic [9:0]  V_SCALE  = 10'h00A;
  localparam logic [9:0]  LIM_MAX  = 10'h1F4;
  localparam logic [9:0]  PINI_MAX = 10'h064;
  localparam logic [9:0]  PWR_MAX  = 10'h12C;
  localparam logic [6:0]  PT_MIN   = 7'h01;
  localparam logic [6:0]  PT_MAX   = 7'h78;
  localparam logic [9:0]  REG_STEP = 10'h00A;
  localparam logic [25:0] PWR_DIV  = 26'h000_6400;
  // time base
  localparam int CLK_NS   = 8;
  localparam int TICK_NS  = 10_000_000;
  localparam int NS_PER_S = 1_000_000_000;
  localparam int HZ50     = 50;
  localparam int HZ60     = 60;
  localparam logic [15:0] TPS = 16'h0064;
  localparam int TICK_CYC_DEF = TICK_NS / CLK_NS;
  localparam int L50_CYC_DEF  = NS_PER_S / (HZ50 * CLK_NS);
  localparam int L60_CYC_DEF  = NS_PER_S / (HZ60 * CLK_NS);
  typedef enum logic [2:0] {M_DUAL, M_CUST, M_JOG, M_R1, M_R2} ssr_mode_t;
  typedef enum logic [2:0] {S_OFF, S_KICK, S_RAMP, S_JOG, S_RUN, S_DEC} ssr_state_t;
  typedef enum logic [1:0] {P_VOLT, P_CURR, P_PWR} ssr_prof_t;
endpackage
`default_nettype wire

// ==== ssr_sequencer.sv ====
// soft start ramp sequencer with AHB-Lite setting registers
`timescale 1ns/1ps
`default_nettype none
module ssr_sequencer #(
  parameter int TICK_CYC = ssr_pkg::TICK_CYC_DEF,
  parameter int L50_CYC  = ssr_pkg::L50_CYC_DEF,
  parameter int L60_CYC  = ssr_pkg::L60_CYC_DEF
) (
  // clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // operator commands
  input  wire logic        start_cmd,
  input  wire logic        stop_cmd,
  input  wire logic        ext_in3,
  // line measurements and motor status
  input  wire logic [6:0]  line_v_pct,
  input  wire logic [9:0]  motor_i_pct,
  input  wire logic [7:0]  power_factor,
  input  wire logic        at_speed,
  input  wire logic        overload_trip,
  // power stage and relays
  output logic      [9:0]  thyristor_firing,
  output logic             limit_active,
  output logic             aux4_relay,
  output logic      [3:0]  aux_relay
);
  typedef struct packed {
    logic [31:0]         ctrl;
    logic [31:0]         r1;
    logic [31:0]         r2;
    logic [31:0]         jk;
    logic [31:0]         dec;
    logic [31:0]         dly;
    logic [31:0]         rdat;
    logic                wr;
    logic [2:0]          idx;
    logic                rdy;
    logic [20:0]         tcnt;
    logic [21:0]         lcnt;
    ssr_pkg::ssr_state_t st;
    ssr_pkg::ssr_prof_t  pf;
    logic [9:0]          lvl;
    logic [9:0]          rf;
    logic [9:0]          tgt;
    logic [9:0]          dlt;
    logic [9:0]          lim;
    logic [9:0]          imeas;
    logic [9:0]          pwr;
    logic [23:0]         acc;
    logic [15:0]         tot;
    logic [15:0]         tmr;
    logic [15:0]         run_t;
    logic [15:0]         spd_t;
    logic                on;
    logic                spd;
    logic                limd;
    logic                aux4;
    logic [3:0]          rly;
  } ssr_st_t;

  localparam ssr_st_t ST_RST = '{ctrl: ssr_pkg::R_CTRL, r1: ssr_pkg::R_R1,
    r2: ssr_pkg::R_R2, jk: ssr_pkg::R_JK, dec: ssr_pkg::R_DEC,
    dly: ssr_pkg::R_DLY, rdy: 1'b1, st: ssr_pkg::S_OFF,
    pf: ssr_pkg::P_VOLT, default: '0};

  ssr_st_t             s_ff;
  ssr_st_t             nxt_s;
  logic                tick;
  logic                lcyc;
  logic                aph;
  logic                hit;
  logic                go;
  logic                mok;
  logic                r2sel;
  logic                hold;
  logic [31:0]         rs;
  logic [31:0]         rdv;
  ssr_pkg::ssr_mode_t  mode;
  ssr_pkg::ssr_prof_t  pt;
  logic [9:0]          ini;
  logic [9:0]          endv;
  logic [9:0]          limv;
  logic [9:0]          meas;
  logic [6:0]          tm;
  logic [21:0]         lp;
  logic [25:0]         pw26;
  logic [9:0]          pmeas;

  function automatic logic [15:0] secs(input logic [7:0] x);
    return 16'(x) * ssr_pkg::TPS;
  endfunction

  function automatic logic [9:0] pct10(input logic [6:0] p);
    return (p > 7'h64) ? ssr_pkg::FULL_V : 10'(p) * ssr_pkg::V_SCALE;
  endfunction

  function automatic logic [9:0] absd(input logic [9:0] a, input logic [9:0] b);
    return (a > b) ? a - b : b - a;
  endfunction

  always_comb begin
    nxt_s = s_ff;
    // bus: address phase captured, write done in data phase
    aph = hsel && htrans[1] && hready;
    hit = (haddr[31:5] == 27'h0) && (haddr[4:2] <= ssr_pkg::A_STAT[4:2]);
    nxt_s.rdy = 1'b1;
    nxt_s.wr = aph && hwrite && hit;
    nxt_s.idx = haddr[4:2];
    unique case (haddr[4:2])
      ssr_pkg::A_CTRL[4:2]: rdv = s_ff.ctrl;
      ssr_pkg::A_R1[4:2]:   rdv = s_ff.r1;
      ssr_pkg::A_R2[4:2]:   rdv = s_ff.r2;
      ssr_pkg::A_JK[4:2]:   rdv = s_ff.jk;
      ssr_pkg::A_DEC[4:2]:  rdv = s_ff.dec;
      ssr_pkg::A_DLY[4:2]:  rdv = s_ff.dly;
      ssr_pkg::A_STAT[4:2]: rdv = {13'h0, s_ff.rly, s_ff.aux4, s_ff.limd,
                                   s_ff.lvl, s_ff.st};
      default:              rdv = 32'h0000_0000;
    endcase
    nxt_s.rdat = (aph && !hwrite && hit) ? rdv : 32'h0000_0000;
    if (s_ff.wr) begin
      unique case (s_ff.idx)
        ssr_pkg::A_CTRL[4:2]: nxt_s.ctrl = hwdata & ssr_pkg::M_CTRL;
        ssr_pkg::A_R1[4:2]:   nxt_s.r1 = hwdata & ssr_pkg::M_RAMP;
        ssr_pkg::A_R2[4:2]:   nxt_s.r2 = hwdata & ssr_pkg::M_RAMP;
        ssr_pkg::A_JK[4:2]:   nxt_s.jk = hwdata & ssr_pkg::M_JK;
        ssr_pkg::A_DEC[4:2]:  nxt_s.dec = hwdata & ssr_pkg::M_DEC;
        ssr_pkg::A_DLY[4:2]:  nxt_s.dly = hwdata & ssr_pkg::M_DLY;
        default: ;
      endcase
    end
    // common time base and line cycle strobe
    tick = (s_ff.tcnt == 21'(TICK_CYC - 1));
    nxt_s.tcnt = tick ? 21'h0 : s_ff.tcnt + 21'h1;
    lp = s_ff.ctrl[ssr_pkg::F_L60] ? 22'(L60_CYC - 1) : 22'(L50_CYC - 1);
    lcyc = (s_ff.lcnt >= lp);
    nxt_s.lcnt = lcyc ? 22'h0 : s_ff.lcnt + 22'h1;
    // true power per line cycle, unity pf is 8'hFF
    pw26 = (26'(line_v_pct) * 26'(motor_i_pct) * 26'(power_factor)) / ssr_pkg::PWR_DIV;
    pmeas = (pw26 > 26'h3FF) ? 10'h3FF : pw26[9:0];
    if (lcyc) begin
      nxt_s.imeas = motor_i_pct;
      nxt_s.pwr = pmeas;
    end
    // start mode and profile choice
    mode = ssr_pkg::ssr_mode_t'(s_ff.ctrl[ssr_pkg::F_MODE+:3]);
    unique case (mode)
      ssr_pkg::M_CUST: mok = s_ff.ctrl[ssr_pkg::F_CUST];
      ssr_pkg::M_DUAL, ssr_pkg::M_JOG, ssr_pkg::M_R1, ssr_pkg::M_R2: mok = 1'b1;
      default: mok = 1'b0;
    endcase
    r2sel = (mode == ssr_pkg::M_R2) || (mode == ssr_pkg::M_DUAL && ext_in3);
    rs = r2sel ? s_ff.r2 : s_ff.r1;
    if (r2sel) pt = s_ff.ctrl[ssr_pkg::F_R2PW] ? ssr_pkg::P_PWR : ssr_pkg::P_VOLT;
    else pt = s_ff.ctrl[ssr_pkg::F_R1CU] ? ssr_pkg::P_CURR : ssr_pkg::P_VOLT;
    limv = (rs[ssr_pkg::F_LIM+:10] > ssr_pkg::LIM_MAX) ? ssr_pkg::LIM_MAX
                                                         : rs[ssr_pkg::F_LIM+:10];
    tm = rs[ssr_pkg::F_TIM+:7];
    unique case (pt)
      ssr_pkg::P_VOLT: begin
        ini = pct10(rs[ssr_pkg::F_INI+:7]);
        endv = ssr_pkg::FULL_V;
      end
      ssr_pkg::P_CURR: begin
        ini = rs[ssr_pkg::F_INI+:10];
        endv = limv;
      end
      ssr_pkg::P_PWR: begin
        ini = (rs[ssr_pkg::F_INI+:10] > ssr_pkg::PINI_MAX) ? ssr_pkg::PINI_MAX
                                                            : rs[ssr_pkg::F_INI+:10];
        endv = (rs[ssr_pkg::F_LIM+:10] > ssr_pkg::PWR_MAX) ? ssr_pkg::PWR_MAX
                                                            : rs[ssr_pkg::F_LIM+:10];
        if (tm < ssr_pkg::PT_MIN) tm = ssr_pkg::PT_MIN;
        if (tm > ssr_pkg::PT_MAX) tm = ssr_pkg::PT_MAX;
      end
      default: begin
        ini = 10'h0;
        endv = 10'h0;
      end
    endcase
    go = start_cmd && !stop_cmd && !overload_trip && mok && s_ff.st == ssr_pkg::S_OFF;
    // reference moves one step toward target per accumulated tick share
    hold = (s_ff.st == ssr_pkg::S_RAMP) && (s_ff.pf == ssr_pkg::P_VOLT) &&
           (s_ff.lim < ssr_pkg::LIM_MAX) && (s_ff.imeas >= s_ff.lim);
    if (tick && !hold && s_ff.rf != s_ff.tgt) begin
      nxt_s.acc = s_ff.acc + 24'(s_ff.dlt);
    end else if (!hold && s_ff.tot != 16'h0 && s_ff.rf != s_ff.tgt &&
                 s_ff.acc >= 24'(s_ff.tot)) begin
      nxt_s.acc = s_ff.acc - 24'(s_ff.tot);
      nxt_s.rf = (s_ff.rf < s_ff.tgt) ? s_ff.rf + 10'h1 : s_ff.rf - 10'h1;
    end
    meas = (s_ff.pf == ssr_pkg::P_PWR) ? s_ff.pwr : s_ff.imeas;
    unique case (s_ff.st)
      ssr_pkg::S_OFF: begin
        if (go) begin
          nxt_s.on = 1'b1;
          nxt_s.run_t = 16'h0;
          nxt_s.spd = 1'b0;
          nxt_s.spd_t = 16'h0;
          if (mode == ssr_pkg::M_JOG) begin
            nxt_s.st = ssr_pkg::S_JOG;
            nxt_s.lvl = pct10(s_ff.jk[ssr_pkg::F_JOG+:7]);
          end else begin
            nxt_s.pf = pt;
            nxt_s.tgt = endv;
            nxt_s.dlt = absd(endv, ini);
            nxt_s.acc = 24'h0;
            nxt_s.tot = secs({1'b0, tm});
            nxt_s.rf = (tm == 7'h0) ? endv : ini;
            nxt_s.lim = limv;
            nxt_s.limd = 1'b1;
            nxt_s.tmr = 16'h0;
            if (s_ff.ctrl[ssr_pkg::F_KICK]) begin
              nxt_s.st = ssr_pkg::S_KICK;
              nxt_s.lvl = pct10(s_ff.jk[ssr_pkg::F_KV+:7]);
            end else begin
              nxt_s.st = ssr_pkg::S_RAMP;
              nxt_s.lvl = (pt == ssr_pkg::P_VOLT) ? nxt_s.rf : 10'h0;
            end
          end
        end
      end
      ssr_pkg::S_KICK: begin
        if (tick) nxt_s.tmr = s_ff.tmr + 16'h1;
        if (s_ff.tmr >= 16'(s_ff.jk[ssr_pkg::F_KT+:8])) begin
          nxt_s.st = ssr_pkg::S_RAMP;
          if (s_ff.pf == ssr_pkg::P_VOLT) nxt_s.lvl = s_ff.rf;
        end
      end
      ssr_pkg::S_RAMP: begin
        if (s_ff.pf == ssr_pkg::P_VOLT) begin
          if (!hold) nxt_s.lvl = s_ff.rf;
        end else if (lcyc) begin
          if (meas < s_ff.rf) begin
            nxt_s.lvl = (s_ff.lvl > ssr_pkg::FULL_V - ssr_pkg::REG_STEP) ?
                        ssr_pkg::FULL_V : s_ff.lvl + ssr_pkg::REG_STEP;
          end else if (meas > s_ff.rf) begin
            nxt_s.lvl = (s_ff.lvl < ssr_pkg::REG_STEP) ? 10'h0
                                                        : s_ff.lvl - ssr_pkg::REG_STEP;
          end
        end
        if (at_speed) begin
          nxt_s.st = ssr_pkg::S_RUN;
          nxt_s.lvl = ssr_pkg::FULL_V;
          nxt_s.limd = 1'b0;
          nxt_s.spd = 1'b1;
        end
      end
      ssr_pkg::S_JOG: ;
      ssr_pkg::S_RUN: nxt_s.lvl = ssr_pkg::FULL_V;
      ssr_pkg::S_DEC: begin
        nxt_s.lvl = s_ff.rf;
        if (s_ff.rf == s_ff.tgt) begin
          nxt_s.st = ssr_pkg::S_OFF;
          nxt_s.lvl = 10'h0;
        end
      end
      default: ;
    endcase
    // stop aborts any start at once; trip drops the output
    if (overload_trip && s_ff.st != ssr_pkg::S_OFF) begin
      nxt_s.st = ssr_pkg::S_OFF;
      nxt_s.lvl = 10'h0;
      nxt_s.limd = 1'b0;
      nxt_s.on = 1'b0;
      nxt_s.spd = 1'b0;
    end else if (stop_cmd && s_ff.st != ssr_pkg::S_OFF && s_ff.st != ssr_pkg::S_DEC) begin
      nxt_s.on = 1'b0;
      nxt_s.spd = 1'b0;
      nxt_s.limd = 1'b0;
      if (s_ff.ctrl[ssr_pkg::F_DEC] && s_ff.st != ssr_pkg::S_JOG) begin
        nxt_s.st = ssr_pkg::S_DEC;
        nxt_s.pf = ssr_pkg::P_VOLT;
        nxt_s.lvl = pct10(s_ff.dec[ssr_pkg::F_DS+:7]);
        nxt_s.tgt = pct10(s_ff.dec[ssr_pkg::F_DE+:7]);
        nxt_s.tot = secs({1'b0, s_ff.dec[ssr_pkg::F_DT+:7]});
        nxt_s.rf = (nxt_s.tot == 16'h0) ? nxt_s.tgt : nxt_s.lvl;
        nxt_s.dlt = absd(nxt_s.lvl, nxt_s.tgt);
        nxt_s.acc = 24'h0;
      end else begin
        nxt_s.st = ssr_pkg::S_OFF;
        nxt_s.lvl = 10'h0;
      end
    end
    // relay delay timers on the same tick
    if (s_ff.on && tick && s_ff.run_t != 16'hFFFF) nxt_s.run_t = s_ff.run_t + 16'h1;
    if (s_ff.spd && tick && s_ff.spd_t != 16'hFFFF) nxt_s.spd_t = s_ff.spd_t + 16'h1;
    nxt_s.rly = 4'h0;
    if (nxt_s.on) begin
      if (s_ff.ctrl[ssr_pkg::F_TMEN] && nxt_s.run_t >=
          16'(secs(s_ff.dly[ssr_pkg::F_TD+:8]) + secs(s_ff.dly[ssr_pkg::F_RD+:8])))
        nxt_s.rly[s_ff.ctrl[ssr_pkg::F_TSEL+:2]] = 1'b1;
      if (s_ff.ctrl[ssr_pkg::F_RDEN] && nxt_s.run_t < secs(s_ff.dly[ssr_pkg::F_RD+:8]))
        nxt_s.rly[s_ff.ctrl[ssr_pkg::F_RSEL+:2]] = 1'b1;
    end
    nxt_s.aux4 = nxt_s.on && nxt_s.spd &&
                 nxt_s.spd_t >= secs(s_ff.dly[ssr_pkg::F_SD+:8]);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) s_ff <= ST_RST;
    else s_ff <= nxt_s;
  end

  assign hrdata           = s_ff.rdat;
  assign hreadyout        = s_ff.rdy;
  assign hresp            = 1'b0;
  assign thyristor_firing = s_ff.lvl;
  assign limit_active     = s_ff.limd;
  assign aux4_relay       = s_ff.aux4;
  assign aux_relay        = s_ff.rly;

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  property p_cust_off;
    (s_ff.st == ssr_pkg::S_OFF && start_cmd && mode == ssr_pkg::M_CUST &&
     !s_ff.ctrl[ssr_pkg::F_CUST]) |=> s_ff.st == ssr_pkg::S_OFF;
  endproperty
  a_cust_off: assert property (p_cust_off) else $error("custom start not ignored");

  property p_jog_lvl;
    s_ff.st == ssr_pkg::S_JOG |-> s_ff.lvl == pct10(s_ff.jk[ssr_pkg::F_JOG+:7]) ||
                                   $past(s_ff.jk) != s_ff.jk;
  endproperty
  a_jog_lvl: assert property (p_jog_lvl) else $error("jog level wrong");

  property p_step;
    (go && mode != ssr_pkg::M_JOG && tm == 7'h0) |=> s_ff.rf == s_ff.tgt;
  endproperty
  a_step: assert property (p_step) else $error("minimum ramp time did not step");

  property p_run;
    s_ff.st == ssr_pkg::S_RUN |-> s_ff.lvl == ssr_pkg::FULL_V && !limit_active;
  endproperty
  a_run: assert property (p_run) else $error("run not full voltage");

  property p_hold;
    (hold && !stop_cmd && !overload_trip && !at_speed) |=> $stable(thyristor_firing);
  endproperty
  a_hold: assert property (p_hold) else $error("output moved under limit");

  property p_dec;
    (stop_cmd && !overload_trip && s_ff.ctrl[ssr_pkg::F_DEC] &&
     s_ff.st inside {ssr_pkg::S_KICK, ssr_pkg::S_RAMP, ssr_pkg::S_RUN})
    |=> s_ff.st == ssr_pkg::S_DEC && s_ff.lvl == pct10($past(s_ff.dec[ssr_pkg::F_DS+:7]));
  endproperty
  a_dec: assert property (p_dec) else $error("soft stop start level wrong");

  property p_abort;
    (stop_cmd && s_ff.st inside {ssr_pkg::S_KICK, ssr_pkg::S_RAMP})
    |=> s_ff.st inside {ssr_pkg::S_DEC, ssr_pkg::S_OFF} && !limit_active;
  endproperty
  a_abort: assert property (p_abort) else $error("stop did not abort start");

  property p_aux4;
    !s_ff.on |-> !aux4_relay && aux_relay == 4'h0;
  endproperty
  a_aux4: assert property (p_aux4) else $error("relay on while stopped");

  property p_timed_off;
    (stop_cmd && s_ff.st != ssr_pkg::S_OFF) |=> aux_relay == 4'h0 ##1
                                                 (aux_relay == 4'h0 || s_ff.on);
  endproperty
  a_timed_off: assert property (p_timed_off) else $error("relay held after stop");

  property p_trip;
    (overload_trip && s_ff.st != ssr_pkg::S_OFF) |=> thyristor_firing == 10'h0 &&
                                                      !limit_active;
  endproperty
  a_trip: assert property (p_trip) else $error("trip left output on");

  c_kick: cover property (s_ff.st == ssr_pkg::S_KICK ##1 s_ff.st == ssr_pkg::S_RAMP);
  c_run: cover property (s_ff.st == ssr_pkg::S_RAMP ##1 s_ff.st == ssr_pkg::S_RUN);
  c_dec: cover property (s_ff.st == ssr_pkg::S_DEC ##1 s_ff.st == ssr_pkg::S_OFF);
  c_a4: cover property (!aux4_relay ##1 aux4_relay);
endmodule // ssr_sequencer
`default_nettype wire

// ==== ssr_motor_model.sv ====
// motor and line model: current follows the firing level, speed and trip on request
`timescale 1ns/1ps
`default_nettype none
module ssr_motor_model (
  // clock and reset
  input  wire logic       hclk,
  input  wire logic       hresetn,
  // power stage drive and bench requests
  input  wire logic [9:0] thyristor_firing,
  input  wire logic       speed_req,
  input  wire logic       trip_req,
  // line measurements and motor status
  output logic      [6:0] line_v_pct,
  output logic      [9:0] motor_i_pct,
  output logic      [7:0] power_factor,
  output logic            at_speed,
  output logic            overload_trip
);
  assign line_v_pct   = 7'h64;
  assign power_factor = 8'hD9;
  // current is 5/16 of the firing level: under the default 500 % limit, but a 100 % limit is reached
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      motor_i_pct   <= 10'h000;
      at_speed      <= 1'b0;
      overload_trip <= 1'b0;
    end else begin
      motor_i_pct   <= (thyristor_firing >> 2) + (thyristor_firing >> 4);
      at_speed      <= speed_req;
      overload_trip <= trip_req;
    end
  end
endmodule // ssr_motor_model
`default_nettype wire

// ==== ssr_sequencer_tb.sv ====
// self-checking bench for the soft start sequencer
`timescale 1ns/1ps
`default_nettype none
module ssr_sequencer_tb;
  localparam int TK = 10;
  localparam int L60 = 17;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0000_0000;
  logic        start_cmd = 1'b0;
  logic        stop_cmd = 1'b0;
  logic        ext_in3 = 1'b0;
  logic        speed_req = 1'b0;
  logic        trip_req = 1'b0;
  logic [31:0] hrdata, rd, fire;
  logic        hreadyout, hresp, at_speed, overload_trip, limit_active, aux4_relay, lim;
  logic [6:0]  line_v_pct;
  logic [9:0]  motor_i_pct, thyristor_firing;
  logic [7:0]  power_factor;
  logic [3:0]  aux_relay;
  logic [31:0] rv [6] = '{ssr_pkg::R_CTRL, ssr_pkg::R_R1, ssr_pkg::R_R2,
                          ssr_pkg::R_JK, ssr_pkg::R_DEC, ssr_pkg::R_DLY};
  logic [31:0] bad [4] = '{32'h1, 32'h5, 32'h6, 32'h7};
  int          failures = 0;
  int          checks_done = 0;
  int          n;
  always #4 hclk = ~hclk;
  ssr_sequencer #(.TICK_CYC(TK), .L50_CYC(20), .L60_CYC(L60)) ssr_sequencer_inst (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .start_cmd(start_cmd), .stop_cmd(stop_cmd),
    .ext_in3(ext_in3), .line_v_pct(line_v_pct), .motor_i_pct(motor_i_pct),
    .power_factor(power_factor), .at_speed(at_speed), .overload_trip(overload_trip),
    .thyristor_firing(thyristor_firing), .limit_active(limit_active),
    .aux4_relay(aux4_relay), .aux_relay(aux_relay));
  ssr_motor_model ssr_motor_model_inst (
    .hclk(hclk), .hresetn(hresetn), .thyristor_firing(thyristor_firing),
    .speed_req(speed_req), .trip_req(trip_req), .line_v_pct(line_v_pct),
    .motor_i_pct(motor_i_pct), .power_factor(power_factor), .at_speed(at_speed),
    .overload_trip(overload_trip));
  task automatic give_verdict();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wait_ready();
    int k;
    k = 0;
    do begin
      @(posedge hclk);
      k++;
    end while (hreadyout !== 1'b1 && k < 50);
    if (hreadyout !== 1'b1) begin
      failures++;
      give_verdict();
    end
  endtask
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= 2'h2;
    hwrite <= w;
    wait_ready();
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_ready();
    rd = hrdata;
  endtask
  // command is taken at the first edge; the answer is sampled just after it
  task automatic cmd(input logic st, input logic sp);
    start_cmd <= st;
    stop_cmd  <= sp;
    @(posedge hclk);
    #1;
    fire = 32'(thyristor_firing);
    lim  = limit_active;
    @(posedge hclk);
    start_cmd <= 1'b0;
    stop_cmd  <= 1'b0;
    @(posedge hclk);
  endtask
  // sel 1 watches the firing level, sel 0 the relays; e is the expected cycle count
  task automatic wait_eq(input logic sel, input logic [9:0] v, input int e);
    int k;
    k = 0;
    while ((sel ? thyristor_firing : {5'h00, aux4_relay, aux_relay}) !== v && k < e + 40) begin
      @(posedge hclk);
      k++;
    end
    check(32'(k >= e - 40 && k < e + 40), 32'h1);
    if (k >= e + 40) begin
      give_verdict();
    end
  endtask
  initial begin
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    check(32'(hreadyout), 32'h1);
    for (int i = 0; i < 6; i++) begin
      bus(1'b0, 32'(4 * i), 32'h0);
      check(rd, rv[i]);
    end
    bus(1'b0, 32'h0000_001C, 32'h0);
    check(rd, 32'h0);
    check(32'(hresp), 32'h0);
    bus(1'b1, 32'h0, 32'hFFFF_FFFF);
    bus(1'b0, 32'h0, 32'h0);
    check(rd, ssr_pkg::M_CTRL);
    foreach (bad[i]) begin
      bus(1'b1, 32'h0, bad[i]);
      cmd(1'b1, 1'b0);
      check(fire, 32'h0);
    end
    bus(1'b1, 32'h0, 32'h2);
    cmd(1'b1, 1'b0);
    check(fire, 32'(ssr_pkg::R_JK[6:0] * ssr_pkg::V_SCALE));
    cmd(1'b0, 1'b1);
    for (int i = 0; i < 2; i++) begin
      ext_in3 <= i[0];
      bus(1'b1, 32'h0, 32'h0);
      cmd(1'b1, 1'b0);
      check(fire, 32'((i ? ssr_pkg::R_R2[9:0] : ssr_pkg::R_R1[9:0]) * ssr_pkg::V_SCALE));
      cmd(1'b0, 1'b1);
    end
    bus(1'b1, 32'h0, 32'h3);
    cmd(1'b1, 1'b0);
    check(fire, 32'(ssr_pkg::R_R1[9:0] * ssr_pkg::V_SCALE));
    check(32'(lim), 32'h1);
    repeat (200) @(posedge hclk);
    check(32'(thyristor_firing > fire[9:0]), 32'h1);
    speed_req <= 1'b1;
    wait_eq(1'b0, 10'h010, 2 * 100 * TK);
    check(32'(thyristor_firing), 32'(ssr_pkg::FULL_V));
    check(32'(limit_active), 32'h0);
    cmd(1'b0, 1'b1);
    check(fire, 32'h0);
    check(32'(aux4_relay), 32'h0);
    speed_req <= 1'b0;
    bus(1'b1, 32'h0, 32'h43);
    cmd(1'b1, 1'b0);
    check(fire, 32'(ssr_pkg::R_JK[13:7] * ssr_pkg::V_SCALE));
    repeat (600) @(posedge hclk);
    check(32'(thyristor_firing < fire[9:0]), 32'h1);
    trip_req <= 1'b1;
    repeat (3) @(posedge hclk);
    check(32'(thyristor_firing), 32'h0);
    check(32'(limit_active), 32'h0);
    trip_req <= 1'b0;
    bus(1'b1, 32'h0, 32'h83);
    cmd(1'b1, 1'b0);
    repeat (20) @(posedge hclk);
    cmd(1'b0, 1'b1);
    check(fire, 32'(ssr_pkg::R_DEC[6:0] * ssr_pkg::V_SCALE));
    wait_eq(1'b1, 10'h000, 10 * 100 * TK);
    bus(1'b1, 32'h0, 32'h6103);
    cmd(1'b1, 1'b0);
    check(32'(aux_relay), 32'h4);
    wait_eq(1'b0, 10'h000, 5 * 100 * TK);
    wait_eq(1'b0, 10'h001, 5 * 100 * TK);
    cmd(1'b0, 1'b1);
    check(32'(aux_relay), 32'h0);
    bus(1'b1, 32'h0, 32'h13);
    cmd(1'b1, 1'b0);
    check(fire, 32'h0);
    repeat (100) @(posedge hclk);
    check(32'(thyristor_firing > 10'h000), 32'h1);
    cmd(1'b0, 1'b1);
    check(fire, 32'h0);
    // voltage ramp: step at minimum time, full ramp in 1 s, then under a 100 % limit
    bus(1'b1, 32'h0, 32'h3);
    bus(1'b1, 32'h4, 32'h0007_D01E);
    cmd(1'b1, 1'b0);
    check(fire, 32'(ssr_pkg::FULL_V));
    cmd(1'b0, 1'b1);
    bus(1'b1, 32'h4, 32'h0017_D01E);
    cmd(1'b1, 1'b0);
    wait_eq(1'b1, ssr_pkg::FULL_V, 100 * TK);
    cmd(1'b0, 1'b1);
    bus(1'b1, 32'h4, 32'h0011_901E);
    cmd(1'b1, 1'b0);
    repeat (500) @(posedge hclk);
    fire = 32'(thyristor_firing);
    repeat (1500) @(posedge hclk);
    check(32'(thyristor_firing), fire);
    check(32'(thyristor_firing < ssr_pkg::FULL_V), 32'h1);
    check(32'(limit_active), 32'h1);
    cmd(1'b0, 1'b1);
    // power ramp on ramp 2 at 60 Hz, time 0 clamps to 1 s, max 80 %
    bus(1'b1, 32'h8, 32'h0001_4014);
    bus(1'b1, 32'h0, 32'h224);
    cmd(1'b1, 1'b0);
    wait_eq(1'b1, ssr_pkg::REG_STEP, 10);
    n = 0;
    while (thyristor_firing == ssr_pkg::REG_STEP && n < 100) begin
      @(posedge hclk);
      n++;
    end
    check(32'(n), 32'(L60));
    repeat (3000) @(posedge hclk);
    check(32'(thyristor_firing > 10'h118 && thyristor_firing < 10'h154), 32'h1);
    check(32'(limit_active), 32'h1);
    cmd(1'b0, 1'b1);
    check(fire, 32'h0);
    give_verdict();
  end
endmodule // ssr_sequencer_tb
`default_nettype wire
